/* src/shk_engine.sv */
// shake detection engine with tilt hold and temporary latch timers
`timescale 1ns/10ps
`default_nettype none
`include "shk_regs.svh"
// How it works
// - threshold built from low and high byte registers limits shake detection
// - shake when any axis sample-to-sample change exceeds threshold
// - 12-bit width limit, high nibble bits 3:0; count limit bits 6:4
// - first shake detection increments counter and starts peak width measurement
// - peak width beyond limit keeps incrementing the counter
// - after shake ends, gap interval measured; gap beyond limit increments counter once and leaves gap phase
// - counter increments whenever peak or gap width limit is exceeded
// - interrupt decision uses threshold, width limit and count limit together
// - tilt hold and latch period timed by 10 Hz tick
// - tilt held 1.6 s plus 0.2 s per code step before acceptance
// - accepted tilt sets tilt interrupt flag on tilt_int_o
// - latch period 200 ms doubling per step to 6400 ms; 110, 111 reserved
// - latch feature runs only when enable bit is one, default off
module shk_engine #(
	// main clock cycles per low speed tick
	parameter int unsigned TICK_CYCLES = `SHK_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// register writes from the host interface
	input wire shk_pkg::shk_wr_t wr_i,
	// samples from the sampling path
	input wire shk_pkg::shk_sample_t sample_i,
	// tilt condition from the tilt comparator
	input wire logic tilt_cond_i,
	// latch request from interrupt logic
	input wire logic latch_req_i,
	// events
	output logic shake_int_o,
	output logic tilt_int_o,
	output logic latch_active_o,
	output logic latch_rearm_o,
	// state views
	output logic [2:0] shake_count_o,
	output logic shake_cond_o
);
	typedef struct packed {
		logic [15:0] limit;
		logic [11:0] width_limit;
		logic [2:0] count_limit;
		logic latch_en;
		logic [2:0] period;
		logic [2:0] tilt_sel;
		logic have_prev;
		logic [15:0] px;
		logic [15:0] py;
		logic [15:0] pz;
		shk_pkg::shk_phase_t phase;
		logic [11:0] width;
		logic [3:0] count;
		logic shake_int;
		logic cond;
		logic [4:0] tilt_ticks;
		logic tilt_int;
		logic latch_active;
		logic [6:0] latch_ticks;
		logic rearm;
	} shk_state_t;
	shk_state_t st, next_st;
	logic tick;
	logic hit;

	// --------------------------------------------------
	// helpers
	// --------------------------------------------------
	// absolute difference of two signed samples
	function automatic logic [16:0] shk_absdiff(input logic [15:0] a, input logic [15:0] b);
		logic signed [16:0] d;
		d = 17'($signed(a)) - 17'($signed(b));
		shk_absdiff = d[16] ? 17'(-d) : 17'(d);
	endfunction : shk_absdiff

	// change beyond threshold on one axis
	function automatic logic shk_over(input logic [15:0] a, input logic [15:0] b,
			input logic [15:0] lim);
		shk_over = shk_absdiff(a, b) > {1'b0, lim};
	endfunction : shk_over

	// --------------------------------------------------
	// low speed tick
	// --------------------------------------------------
	shk_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	// shake condition on any axis against the programmed limit
	assign hit = st.have_prev && (shk_over(sample_i.x, st.px, st.limit) ||
		shk_over(sample_i.y, st.py, st.limit) || shk_over(sample_i.z, st.pz, st.limit));

	// --------------------------------------------------
	// next state
	// --------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.shake_int = 1'b0;
		next_st.rearm = 1'b0;
		// register writes
		if (wr_i.write) begin
			if (wr_i.addr == `SHK_ADDR_LIMIT_LOW) begin
				next_st.limit[7:0] = wr_i.data;
			end else if (wr_i.addr == `SHK_ADDR_LIMIT_HIGH) begin
				next_st.limit[15:8] = wr_i.data;
			end else if (wr_i.addr == `SHK_ADDR_WIDTH_LOW) begin
				next_st.width_limit[7:0] = wr_i.data;
			end else if (wr_i.addr == `SHK_ADDR_WIDTH_HIGH) begin
				next_st.width_limit[11:8] = wr_i.data[`SHK_WIDTH_HI_MSB:0];
				next_st.count_limit = wr_i.data[`SHK_COUNT_MSB:`SHK_COUNT_LSB];
			end else if (wr_i.addr == `SHK_ADDR_TIMER_CTRL) begin
				next_st.latch_en = wr_i.data[`SHK_LATCH_EN_BIT];
				next_st.period = wr_i.data[`SHK_PERIOD_MSB:`SHK_PERIOD_LSB];
				next_st.tilt_sel = wr_i.data[`SHK_TILT_MSB:`SHK_TILT_LSB];
			end
		end
		// shake engine, one step per sample
		if (sample_i.valid) begin
			next_st.have_prev = 1'b1;
			next_st.px = sample_i.x;
			next_st.py = sample_i.y;
			next_st.pz = sample_i.z;
			next_st.cond = hit;
			case (st.phase)
				shk_pkg::SHK_IDLE: begin
					if (hit) begin
						next_st.phase = shk_pkg::SHK_PEAK;
						next_st.count = st.count + 4'h1;
						next_st.width = 12'h0;
					end
				end
				shk_pkg::SHK_PEAK: begin
					if (!hit) begin
						next_st.phase = shk_pkg::SHK_GAP;
						next_st.width = 12'h0;
					end else if (st.width > st.width_limit) begin
						next_st.count = st.count + 4'h1;
						next_st.width = 12'h0;
					end else begin
						next_st.width = st.width + 12'h1;
					end
				end
				shk_pkg::SHK_GAP: begin
					if (st.width > st.width_limit) begin
						next_st.count = st.count + 4'h1;
						next_st.width = 12'h0;
						next_st.phase = hit ? shk_pkg::SHK_PEAK : shk_pkg::SHK_IDLE;
					end else if (hit) begin
						next_st.phase = shk_pkg::SHK_PEAK;
						next_st.width = 12'h0;
					end else begin
						next_st.width = st.width + 12'h1;
					end
				end
				default: begin
					next_st.phase = shk_pkg::SHK_IDLE;
				end
			endcase
			// decision uses limit, width and count limit together
			if (next_st.count > {1'b0, st.count_limit}) begin
				next_st.shake_int = 1'b1;
				next_st.count = 4'h0;
				next_st.phase = shk_pkg::SHK_IDLE;
			end
		end
		// tilt hold timer on the slow tick
		if (!tilt_cond_i) begin
			next_st.tilt_ticks = 5'h0;
			next_st.tilt_int = 1'b0;
		end else if (tick && !st.tilt_int) begin
			if (st.tilt_ticks + 5'h1 >= `SHK_TILT_BASE_TICKS +
					5'(st.tilt_sel * `SHK_TILT_STEP_TICKS)) begin
				next_st.tilt_int = 1'b1;
			end else begin
				next_st.tilt_ticks = st.tilt_ticks + 5'h1;
			end
		end
		// temporary latch timer
		if (!st.latch_en) begin
			next_st.latch_active = 1'b0;
			next_st.latch_ticks = 7'h0;
		end else if (!st.latch_active) begin
			if (latch_req_i) begin
				next_st.latch_active = 1'b1;
				next_st.latch_ticks = 7'h0;
			end
		end else if (tick) begin
			if (st.period <= `SHK_PERIOD_MAX && st.latch_ticks + 7'h1 >=
					7'(`SHK_LATCH_BASE_TICKS << st.period)) begin
				next_st.latch_active = 1'b0;
				next_st.rearm = 1'b1;
			end else begin
				next_st.latch_ticks = st.latch_ticks + 7'h1;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs from flip-flops
	assign shake_int_o = st.shake_int;
	assign tilt_int_o = st.tilt_int;
	assign latch_active_o = st.latch_active;
	assign latch_rearm_o = st.rearm;
	assign shake_count_o = st.count[2:0];
	assign shake_cond_o = st.cond;
endmodule : shk_engine
`default_nettype wire

/* shared/shk_regs.svh */
// register offsets, fields, reset values and timing counts of the shake and timer block
`ifndef SHK_REGS_SVH
`define SHK_REGS_SVH
`define SHK_ADDR_LIMIT_LOW 8'h46
`define SHK_ADDR_LIMIT_HIGH 8'h47
`define SHK_ADDR_WIDTH_LOW 8'h48
`define SHK_ADDR_WIDTH_HIGH 8'h49
`define SHK_ADDR_TIMER_CTRL 8'h4A
`define SHK_RESET_BYTE 8'h00
`define SHK_LATCH_EN_BIT 7
`define SHK_PERIOD_MSB 6
`define SHK_PERIOD_LSB 4
`define SHK_TILT_MSB 2
`define SHK_TILT_LSB 0
`define SHK_WIDTH_HI_MSB 3
`define SHK_COUNT_MSB 6
`define SHK_COUNT_LSB 4
`define SHK_CLK_HZ 40000000
`define SHK_SLOW_HZ 10
`define SHK_TICK_CYCLES (`SHK_CLK_HZ / `SHK_SLOW_HZ)
`define SHK_TILT_BASE_TICKS 5'h10
`define SHK_TILT_STEP_TICKS 5'h02
`define SHK_LATCH_BASE_TICKS 7'h02
`define SHK_PERIOD_MAX 3'h5
`endif

/* shared/shk_pkg.sv */
// types shared by the shake and timer block
package shk_pkg;
	typedef enum logic [1:0] {
		SHK_IDLE = 2'h0,
		SHK_PEAK = 2'h1,
		SHK_GAP = 2'h3
	} shk_phase_t;
	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [7:0] data;
	} shk_wr_t;
	typedef struct packed {
		logic valid;
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} shk_sample_t;
endpackage : shk_pkg

/* src/shk_tick.sv */
// divider giving the 10 Hz low speed tick as a one cycle enable
`timescale 1ns/10ps
`default_nettype none
`include "shk_regs.svh"
module shk_tick #(
	parameter int unsigned TICK_CYCLES = `SHK_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// tick out
	output logic tick_o
);
	typedef struct packed {
		logic [22:0] cnt;
		logic tick;
	} shk_tick_state_t;
	shk_tick_state_t st, next_st;
	// count down and pulse on wrap
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 23'h0) begin
			next_st.cnt = 23'(TICK_CYCLES - 1);
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt - 23'h1;
		end
	end
	// state register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tick_o = st.tick;
endmodule : shk_tick
`default_nettype wire

/* verif/shk_engine_chk.sv */
// port assertions of the shake and timer engine
`timescale 1ns/10ps
`default_nettype none
module shk_engine_chk (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// inputs
	input wire shk_pkg::shk_sample_t sample_i,
	input wire logic tilt_cond_i,
	input wire logic latch_req_i,
	// outputs
	input wire logic shake_int_o,
	input wire logic tilt_int_o,
	input wire logic latch_active_o,
	input wire logic latch_rearm_o,
	input wire logic [2:0] shake_count_o,
	input wire logic shake_cond_o
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_int_one_pulse: assert property (shake_int_o && !sample_i.valid |=> !shake_int_o)
		else $error("shake pulse too long");
	a_int_clears_count: assert property (shake_int_o |-> shake_count_o == 3'h0)
		else $error("count not cleared");
	a_int_from_sample: assert property (shake_int_o |-> $past(sample_i.valid))
		else $error("shake pulse without sample");
	a_count_steps_one: assert property ($changed(shake_count_o) && !shake_int_o
		|-> shake_count_o == $past(shake_count_o) + 3'h1) else $error("count step");
	a_count_from_sample: assert property ($changed(shake_count_o) |-> $past(sample_i.valid))
		else $error("count moved without sample");
	a_cond_from_sample: assert property ($changed(shake_cond_o) |-> $past(sample_i.valid))
		else $error("condition moved without sample");
	a_tilt_drops_fast: assert property (!tilt_cond_i |=> !tilt_int_o)
		else $error("tilt flag stayed");
	a_rearm_one_pulse: assert property (latch_rearm_o |=> !latch_rearm_o)
		else $error("rearm pulse too long");
	a_rearm_after_run: assert property (latch_rearm_o |-> $past(latch_active_o))
		else $error("rearm without latch");
	a_latch_from_req: assert property ($rose(latch_active_o) |-> $past(latch_req_i))
		else $error("latch without request");
	// main scenarios reached
	c_shake: cover property (shake_int_o);
	c_count_two: cover property (shake_count_o == 3'h2);
	c_latch: cover property (latch_active_o);
endmodule : shk_engine_chk
bind shk_engine shk_engine_chk u_chk (.ref_clk_i, .sys_rst_i, .sample_i, .tilt_cond_i,
	.latch_req_i, .shake_int_o, .tilt_int_o, .latch_active_o, .latch_rearm_o,
	.shake_count_o, .shake_cond_o);
`default_nettype wire

/* verif/shk_engine_tb.sv */
// self-checking testbench of the shake and timer engine
`timescale 1ns/10ps
`default_nettype none
module shk_engine_tb;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	shk_pkg::shk_wr_t wr_i = '0;
	shk_pkg::shk_sample_t sample_i = '0;
	logic tilt_cond_i = 1'b0;
	logic latch_req_i = 1'b0;
	logic shake_int_o, tilt_int_o, latch_active_o, latch_rearm_o, shake_cond_o, seen;
	logic [2:0] shake_count_o;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int n = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	// short tick so both timers run out within the run
	shk_engine #(.TICK_CYCLES(10)) u_dut (.ref_clk_i, .sys_rst_i, .wr_i, .sample_i,
		.tilt_cond_i, .latch_req_i, .shake_int_o, .tilt_int_o, .latch_active_o,
		.latch_rearm_o, .shake_count_o, .shake_cond_o);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// hang guard
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end
	task chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
		compares++;
		if (seen_v !== exp_v) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		wr_i <= '{1'b1, a, d};
		@(posedge ref_clk_i);
		wr_i <= '0;
		@(posedge ref_clk_i);
	endtask : wr
	// one sample, any shake pulse caught in seen
	task smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
		sample_i <= '{1'b1, x, y, z};
		@(posedge ref_clk_i);
		sample_i <= '0;
		seen = 1'b0;
		repeat (2) begin
			@(negedge ref_clk_i);
			seen = seen | shake_int_o;
		end
		@(posedge ref_clk_i);
	endtask : smp
	task req;
		latch_req_i <= 1'b1;
		@(posedge ref_clk_i);
		latch_req_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
	endtask : req
	// cycles until rearm or tilt flag is seen mid cycle, zero if not within lim
	task wait_out(input logic pick_tilt, input int lim, output int cnt);
		logic hit_v;
		hit_v = 1'b0;
		cnt = 0;
		while (!hit_v && cnt < lim) begin
			@(negedge ref_clk_i);
			cnt++;
			hit_v = pick_tilt ? tilt_int_o : latch_rearm_o;
		end
		if (!hit_v)
			cnt = 0;
		@(posedge ref_clk_i);
	endtask : wait_out
	task end_sim;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_thresh;
		chk(8'({shake_int_o, tilt_int_o, latch_active_o, latch_rearm_o}), 8'h00);
		chk(8'({shake_cond_o, shake_count_o}), 8'h00);
		wr(8'h46, 8'h10);
		wr(8'h47, 8'h00);
		wr(8'h48, 8'hFF);
		wr(8'h49, 8'h00);
		smp(16'h0000, 16'h0000, 16'h0000);
		smp(16'h0010, 16'h0000, 16'h0000);
		chk(8'({seen, shake_cond_o}), 8'h00);
		smp(16'h0010, 16'hFFEF, 16'h0000);
		chk(8'({seen, shake_count_o}), 8'h08);
		wr(8'h47, 8'h01);
		wr(8'h4B, 8'h00);
		smp(16'h0010, 16'h000F, 16'h0000);
		chk(8'({seen, shake_cond_o}), 8'h00);
		smp(16'h0010, 16'h000F, 16'h0111);
		chk(8'({seen, shake_cond_o}), 8'h03);
		$display("threshold test done");
	endtask : t_thresh
	task t_count;
		wr(8'h47, 8'h00);
		wr(8'h48, 8'h00);
		wr(8'h49, 8'h30);
		smp(16'h0200, 16'h000F, 16'h0111);
		chk(8'({shake_cond_o, shake_count_o}), 8'h09);
		smp(16'h0000, 16'h000F, 16'h0111);
		chk(8'(shake_count_o), 8'h01);
		smp(16'h0200, 16'h000F, 16'h0111);
		chk(8'(shake_count_o), 8'h02);
		smp(16'h0200, 16'h000F, 16'h0111);
		chk(8'({shake_cond_o, shake_count_o}), 8'h02);
		smp(16'h0200, 16'h000F, 16'h0111);
		chk(8'(shake_count_o), 8'h02);
		smp(16'h0200, 16'h000F, 16'h0111);
		chk(8'({seen, shake_count_o}), 8'h03);
		smp(16'h0000, 16'h000F, 16'h0111);
		chk(8'({seen, shake_count_o}), 8'h08);
		$display("count test done");
	endtask : t_count
	task t_timers;
		req();
		chk(8'(latch_active_o), 8'h00);
		wr(8'h4A, 8'h80);
		req();
		chk(8'(latch_active_o), 8'h01);
		wait_out(1'b0, 40, n);
		chk(8'(n >= 10 && n <= 20), 8'h01);
		chk(8'(latch_active_o), 8'h00);
		wr(8'h4A, 8'h90);
		req();
		wait_out(1'b0, 80, n);
		chk(8'(n >= 30 && n <= 40), 8'h01);
		wr(8'h4A, 8'hE0);
		req();
		wait_out(1'b0, 100, n);
		chk(8'({latch_active_o, n == 0}), 8'h03);
		wr(8'h4A, 8'h01);
		@(posedge ref_clk_i);
		chk(8'(latch_active_o), 8'h00);
		tilt_cond_i <= 1'b1;
		wait_out(1'b1, 250, n);
		chk(8'(n >= 171 && n <= 182), 8'h01);
		chk(8'(tilt_int_o), 8'h01);
		tilt_cond_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		chk(8'(tilt_int_o), 8'h00);
		$display("timer test done");
	endtask : t_timers
	// main sequence
	initial begin
		repeat (8) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		t_thresh();
		t_count();
		t_timers();
		end_sim();
	end
endmodule : shk_engine_tb
`default_nettype wire
